// ==== verilog/gpx_pkg.sv ====
// Purpose: constants for the 16-bit two-wire gpio expander
// Assumes: 100 MHz system clock, bus pins oversampled
// Notes: register pointer values follow the command byte encoding
`default_nettype none
package gpx_pkg;
  // ****************************************
  // register pointers
  // ****************************************
  localparam logic [3:0] GPX_PTR_IN0 = 4'h0;
  localparam logic [3:0] GPX_PTR_IN1 = 4'h1;
  localparam logic [3:0] GPX_PTR_OUT0 = 4'h2;
  localparam logic [3:0] GPX_PTR_OUT1 = 4'h3;
  localparam logic [3:0] GPX_PTR_POL0 = 4'h4;
  localparam logic [3:0] GPX_PTR_POL1 = 4'h5;
  localparam logic [3:0] GPX_PTR_CFG0 = 4'h6;
  localparam logic [3:0] GPX_PTR_CFG1 = 4'h7;
  // ****************************************
  // reset values and address
  // ****************************************
  localparam logic [7:0] GPX_OUT_RST = 8'hFF;
  localparam logic [7:0] GPX_POL_RST = 8'h00;
  localparam logic [7:0] GPX_CFG_RST = 8'hFF;
  localparam logic [4:0] GPX_ADDR_BASE = 5'h1D;
  localparam int GPX_BIT_CNT = 8;
  localparam logic [3:0] GPX_BIT_LAST = 4'h7;
  // sync depth plus the capture edge before the engine may run
  localparam logic [1:0] GPX_SETTLE = 2'h3;
  // ****************************************
  // bus engine states (gray along main path)
  // ****************************************
  typedef enum logic [2:0] {
    GPX_IDLE = 3'h0,
    GPX_ADDR = 3'h1,
    GPX_AACK = 3'h3,
    GPX_WRX = 3'h2,
    GPX_WACK = 3'h6,
    GPX_RTX = 3'h7,
    GPX_RACK = 3'h5
  } gpx_st_t;
endpackage
`default_nettype wire

// ==== verilog/gpx_sync.sv ====
// Purpose: two-flop synchroniser bank for pin inputs
// Assumes: single clock domain clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module gpx_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpx_sync_t;
  gpx_sync_t st_r;
  gpx_sync_t st_nxt;
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule // gpx_sync
`default_nettype wire

// ==== verilog/gpx_top.sv ====
// Purpose: 16-bit gpio expander behind a two-wire bus target
// Assumes: scl/sda oversampled by clk; external pull-ups on open-drain lines
// Notes: rst_n combines power-on and the external reset pin
`timescale 1ns/1ps
`default_nettype none
module gpx_top
  import gpx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic bus_addr_pin_lo,
  input wire logic bus_addr_pin_hi,
  input wire logic [7:0] lower_bank_io_i,
  output logic [7:0] lower_bank_io_o,
  output logic [7:0] lower_bank_io_oe,
  input wire logic [7:0] upper_bank_io_i,
  output logic [7:0] upper_bank_io_o,
  output logic [7:0] upper_bank_io_oe,
  output logic alert_n_o,
  output logic alert_n_oe
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  // one bank for bus lines, pins and straps keeps their lag equal
  logic [19:0] raw;
  logic [19:0] syn;
  assign raw = {scl_i, sda_i, upper_bank_io_i, lower_bank_io_i,
                bus_addr_pin_hi, bus_addr_pin_lo};
  gpx_sync #(.W(20)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(raw),
    .q(syn)
  );
  logic scl_s;
  logic sda_s;
  logic [15:0] pin_s;
  logic [1:0] addr_s;
  assign scl_s = syn[19];
  assign sda_s = syn[18];
  assign pin_s = syn[17:2];
  assign addr_s = syn[1:0];

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    gpx_st_t st;
    logic scl_d;
    logic sda_d;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic rd;
    logic first;
    logic [3:0] ptr;
    logic [15:0] outv;
    logic [15:0] pol;
    logic [15:0] cfg;
    logic [15:0] inreg;
    logic sda_low;
    logic [1:0] addr;
    logic [1:0] settle;
  } gpx_state_t;
  gpx_state_t s_r;
  gpx_state_t s_nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [15:0] in_now;
  logic [6:0] my_addr;
  logic settled;
  logic [7:0] rd_byte;
  assign scl_rise = scl_s & ~s_r.scl_d;
  assign scl_fall = ~scl_s & s_r.scl_d;
  assign start_c = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
  assign stop_c = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;
  // polarity applies to the input register and the alert compare alike
  assign in_now = pin_s ^ s_r.pol;
  // engine and alert wait until straps and pins have crossed the
  // synchroniser; its reset value would otherwise look like bus edges
  assign settled = s_r.settle == GPX_SETTLE;
  assign my_addr = {GPX_ADDR_BASE, s_r.addr};

  function automatic logic [7:0] rd_mux(input logic [3:0] p,
                                        input logic [15:0] inv,
                                        input logic [15:0] o,
                                        input logic [15:0] pl,
                                        input logic [15:0] c);
    logic [7:0] v;
    v = 8'h00;
    unique case (p[2:0])
      3'h0: v = inv[7:0];
      3'h1: v = inv[15:8];
      3'h2: v = o[7:0];
      3'h3: v = o[15:8];
      3'h4: v = pl[7:0];
      3'h5: v = pl[15:8];
      3'h6: v = c[7:0];
      3'h7: v = c[15:8];
    endcase
    // unused pointers read back as zero
    if (p[3]) begin
      v = 8'h00;
    end
    return v;
  endfunction

  // input bytes report live levels, taken when the byte is loaded
  assign rd_byte = rd_mux(s_r.ptr, in_now, s_r.outv, s_r.pol, s_r.cfg);

  // ****************************************
  // bus engine and register file
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_d = scl_s;
    s_nxt.sda_d = sda_s;
    if (!settled) begin
      s_nxt.settle = s_r.settle + 2'h1;
      s_nxt.addr = addr_s;
      // register starts equal to the pins, so no alert follows reset
      s_nxt.inreg = in_now;
    end else if (start_c) begin
      // a repeated start restarts address decode mid-frame
      s_nxt.st = GPX_ADDR;
      s_nxt.bcnt = 4'h0;
      s_nxt.sda_low = 1'b0;
    end else if (stop_c) begin
      // stop ends the frame even in the middle of a byte
      s_nxt.st = GPX_IDLE;
      s_nxt.sda_low = 1'b0;
    end else begin
      unique case (s_r.st)
        GPX_IDLE: begin
          // idle ignores everything but a start
          s_nxt.sda_low = 1'b0;
        end
        GPX_ADDR, GPX_WRX: begin
          if (scl_rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda_s};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
          end
          if (scl_fall && s_r.bcnt == 4'(GPX_BIT_CNT)) begin
            s_nxt.bcnt = 4'h0;
            if (s_r.st == GPX_ADDR) begin
              if (s_r.sh[7:1] == my_addr) begin
                s_nxt.rd = s_r.sh[0];
                s_nxt.first = ~s_r.sh[0];
                s_nxt.sda_low = 1'b1;
                s_nxt.st = GPX_AACK;
              end else begin
                // not ours: stay off the bus until the next start
                s_nxt.st = GPX_IDLE;
              end
            end else begin
              // ack is pulled from the fall after the eighth bit
              s_nxt.sda_low = 1'b1;
              s_nxt.st = GPX_WACK;
              if (s_r.first) begin
                s_nxt.ptr = s_r.sh[3:0];
                s_nxt.first = 1'b0;
              end else begin
                unique case (s_r.ptr)
                  GPX_PTR_OUT0: s_nxt.outv[7:0] = s_r.sh;
                  GPX_PTR_OUT1: s_nxt.outv[15:8] = s_r.sh;
                  GPX_PTR_POL0: s_nxt.pol[7:0] = s_r.sh;
                  GPX_PTR_POL1: s_nxt.pol[15:8] = s_r.sh;
                  GPX_PTR_CFG0: s_nxt.cfg[7:0] = s_r.sh;
                  GPX_PTR_CFG1: s_nxt.cfg[15:8] = s_r.sh;
                  // input registers and pointers 8 to F drop writes
                  default: ;
                endcase
                // pair auto-toggles within its register pair
                s_nxt.ptr = {s_r.ptr[3:1], ~s_r.ptr[0]};
              end
            end
          end
        end
        GPX_AACK, GPX_WACK: begin
          if (scl_fall) begin
            // release the ack; a read loads its first byte
            s_nxt.sda_low = 1'b0;
            if (s_r.rd) begin
              s_nxt.sh = rd_byte;
              // first bit goes out on the fall and stands the high phase
              s_nxt.sda_low = ~rd_byte[7];
              s_nxt.bcnt = 4'h0;
              s_nxt.st = GPX_RTX;
            end else begin
              s_nxt.st = GPX_WRX;
            end
          end
        end
        GPX_RTX: begin
          if (scl_fall) begin
            if (s_r.bcnt == GPX_BIT_LAST) begin
              s_nxt.sda_low = 1'b0;
              s_nxt.st = GPX_RACK;
            end else begin
              // next bit is set up on the fall, read by the master on rise
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_low = ~s_r.sh[6];
              s_nxt.bcnt = s_r.bcnt + 4'h1;
            end
          end
        end
        GPX_RACK: begin
          if (scl_rise) begin
            // input read refreshes register
            // a level change between byte load and ack raises the alert only until
            // the ack refreshes the register; the master has to poll to see it
            if (s_r.ptr[3:1] == 3'h0) begin
              if (s_r.ptr[0]) begin
                s_nxt.inreg[15:8] = in_now[15:8];
              end else begin
                s_nxt.inreg[7:0] = in_now[7:0];
              end
            end
            // an ack goes on with the other register of the pair
            s_nxt.ptr = {s_r.ptr[3:1], ~s_r.ptr[0]};
            if (sda_s) begin
              s_nxt.st = GPX_IDLE;
            end else begin
              s_nxt.st = GPX_AACK;
            end
          end
        end
        default: s_nxt.st = GPX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.outv <= {GPX_OUT_RST, GPX_OUT_RST};
      s_r.pol <= {GPX_POL_RST, GPX_POL_RST};
      s_r.cfg <= {GPX_CFG_RST, GPX_CFG_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // pins
  // ****************************************
  assign sda_o = 1'b0;
  assign sda_oe = s_r.sda_low;

  logic [1:0][7:0] bank_o;
  logic [1:0][7:0] bank_oe;
  // enables come straight from flops, steady from reset
  // bank b, pin n is register bit 8*b+n
  for (genvar b = 0; b < 2; b++) begin : g_bank
    assign bank_o[b] = s_r.outv[8*b +: 8];
    assign bank_oe[b] = ~s_r.cfg[8*b +: 8];
  end
  assign lower_bank_io_o = bank_o[0];
  assign upper_bank_io_o = bank_o[1];
  assign lower_bank_io_oe = bank_oe[0];
  assign upper_bank_io_oe = bank_oe[1];

  // clears when levels match
  // kept quiet while the synchroniser settles after reset
  assign alert_n_o = 1'b0;
  assign alert_n_oe = settled & (|(in_now ^ s_r.inreg));
endmodule // gpx_top
`default_nettype wire

// ==== tb/gpx_top_asserts.sv ====
// Purpose: pin and bus checks on the expander top
// Assumes: bus idle means both lines high
// Notes: bound to gpx_top from the bench
`timescale 1ns/1ps
`default_nettype none
module gpx_top_chk
  import gpx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [7:0] lower_bank_io_i,
  input wire logic [7:0] lower_bank_io_o,
  input wire logic [7:0] lower_bank_io_oe,
  input wire logic [7:0] upper_bank_io_o,
  input wire logic [7:0] upper_bank_io_oe,
  input wire logic alert_n_o,
  input wire logic alert_n_oe
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_idle;
    (scl_i && sda_i) [*8];
  endsequence
  property p_rst_def;
    $rose(rst_n) |-> !sda_oe && !alert_n_oe && lower_bank_io_oe == 8'h00
      && upper_bank_io_oe == 8'h00 && lower_bank_io_o == GPX_OUT_RST;
  endproperty
  a_rst_def: assert property (p_rst_def) else $error("bad reset");
  property p_open_drain;
    alert_n_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("drive hi");
  property p_alert_rise;
    s_idle ##0 ($changed(lower_bank_io_i) && !alert_n_oe) |-> ##[1:4] alert_n_oe;
  endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("no alert");
  property p_out_hold;
    s_idle |=> $stable(lower_bank_io_o) && $stable(upper_bank_io_o);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("out moved");
  property p_oe_hold;
    s_idle |=> $stable(lower_bank_io_oe) && $stable(upper_bank_io_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
  property p_ack_idle;
    s_idle |-> !sda_oe;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("sda pulled");
  property p_bank_out;
    $changed(lower_bank_io_o) |-> $stable(upper_bank_io_o);
  endproperty
  a_bank_out: assert property (p_bank_out) else $error("bank mix");
  property p_bank_oe;
    $changed(lower_bank_io_oe) |-> $stable(upper_bank_io_oe);
  endproperty
  a_bank_oe: assert property (p_bank_oe) else $error("bank oe mix");
endmodule // gpx_top_chk
`default_nettype wire

// ==== tb/gpx_master.sv ====
// Purpose: bit-banged bus master model
// Assumes: pull-up on the data line, resolved by the bench
// Notes: clock line stands high between frames
`timescale 1ns/1ps
`default_nettype none
module gpx_master (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // slow third-of-a-bit step so the pin synchroniser never misses an edge
  task automatic half;
    repeat (20) @(posedge clk);
    #1;
  endtask
  task automatic start;
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop;
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_low = !b;
    half();
    scl = 1'b1;
    half();
    r = sda_in;
    scl = 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ad,
                      output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ad, ak);
  endtask
  task automatic wr(input logic [6:0] a, input logic [3:0] p,
                    input logic [7:0] d, output logic ak);
    logic [7:0] x;
    logic k;
    start();
    xfer({a, 1'b0}, 1'b1, x, ak);
    xfer({4'h0, p}, 1'b1, x, k);
    xfer(d, 1'b1, x, k);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [3:0] p,
                    output logic [7:0] q);
    logic [7:0] x;
    logic k;
    start();
    xfer({a, 1'b0}, 1'b1, x, k);
    xfer({4'h0, p}, 1'b1, x, k);
    start();
    xfer({a, 1'b1}, 1'b1, x, k);
    xfer(8'hFF, 1'b1, q, k);
    stop();
  endtask
endmodule // gpx_master
`default_nettype wire

// ==== tb/gpx_top_tb_top.sv ====
// Purpose: self-checking bench for the expander
// Assumes: 100 MHz clock, master model on the bus
// Notes: row table covers plain register writes and one unused pointer
`timescale 1ns/1ps
`default_nettype none
module gpx_top_tb_top
  import gpx_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl_i, sda_i, sda_low, sda_o, sda_oe, alert_n_o, alert_n_oe, ak;
  logic bus_addr_pin_lo = 1'b0;
  logic bus_addr_pin_hi = 1'b0;
  logic [7:0] lower_bank_io_i = 8'h00;
  logic [7:0] upper_bank_io_i = 8'h00;
  logic [7:0] lower_bank_io_o, lower_bank_io_oe, q;
  logic [7:0] upper_bank_io_o, upper_bank_io_oe;
  logic [6:0] dev;
  int checks = 0;
  int bad_count = 0;
  int cyc = 0;
  // pointer, write data, read-back value
  localparam logic [19:0] ROWS [6] = '{20'h2A5A5, 20'h33C3C, 20'h40F0F,
                                       20'h60F0F, 20'h70000, 20'h83300};
  assign sda_i = !(sda_low || sda_oe);
  assign dev = {GPX_ADDR_BASE, bus_addr_pin_hi, bus_addr_pin_lo};
  always #5 clk = ~clk;
  gpx_top gpx_top_inst (.clk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe,
    .bus_addr_pin_lo, .bus_addr_pin_hi, .lower_bank_io_i, .lower_bank_io_o,
    .lower_bank_io_oe, .upper_bank_io_i, .upper_bank_io_o,
    .upper_bank_io_oe, .alert_n_o, .alert_n_oe);
  gpx_master gpx_master_inst (.clk, .sda_in(sda_i), .scl(scl_i), .sda_low);
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    do_reset();
    chk8(lower_bank_io_oe | upper_bank_io_oe, 8'h00);
    chk8(lower_bank_io_o, GPX_OUT_RST);
    chk8({7'h00, alert_n_oe}, 8'h00);
    foreach (ROWS[i]) begin
      gpx_master_inst.wr(dev, ROWS[i][19:16], ROWS[i][15:8], ak);
      gpx_master_inst.rd(dev, ROWS[i][19:16], q);
      chk8(q, ROWS[i][7:0]);
    end
    chk8(lower_bank_io_o, 8'hA5);
    chk8(lower_bank_io_oe, 8'hF0);
    chk8(upper_bank_io_oe, 8'hFF);
    chk8(upper_bank_io_o, 8'h3C);
    lower_bank_io_i = 8'h5A;
    upper_bank_io_i = 8'hC3;
    repeat (5) @(posedge clk);
    #1;
    chk8({7'h00, alert_n_oe}, 8'h01);
    gpx_master_inst.rd(dev, GPX_PTR_IN0, q);
    chk8(q, 8'h55);
    gpx_master_inst.rd(dev, GPX_PTR_IN1, q);
    chk8(q, 8'hC3);
    chk8({7'h00, alert_n_oe}, 8'h00);
    lower_bank_io_i = 8'h5B;
    repeat (5) @(posedge clk);
    #1;
    chk8({7'h00, alert_n_oe}, 8'h01);
    lower_bank_io_i = 8'h5A;
    repeat (5) @(posedge clk);
    #1;
    chk8({7'h00, alert_n_oe}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      {bus_addr_pin_hi, bus_addr_pin_lo} = k[1:0];
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk8(lower_bank_io_o & upper_bank_io_o, 8'hFF);
      chk8(lower_bank_io_oe | upper_bank_io_oe, 8'h00);
      do_reset();
      gpx_master_inst.wr(dev ^ 7'h01, GPX_PTR_OUT0, 8'h00, ak);
      chk8({7'h00, ak}, 8'h01);
      gpx_master_inst.wr(dev, GPX_PTR_OUT0, 8'h00, ak);
      chk8({7'h00, ak}, 8'h00);
      chk8(lower_bank_io_o, 8'h00);
    end
    print_verdict();
  end
endmodule // gpx_top_tb_top
bind gpx_top gpx_top_chk gpx_top_chk_inst (.clk, .rst_n, .scl_i, .sda_i,
  .sda_o, .sda_oe, .lower_bank_io_i, .lower_bank_io_o, .lower_bank_io_oe,
  .upper_bank_io_o, .upper_bank_io_oe, .alert_n_o, .alert_n_oe);
`default_nettype wire
